// ==== hw/art_map.svh ====
`ifndef ART_MAP_SVH
`define ART_MAP_SVH
// prescaler divide ratios
`define ART_SYS_DIV 12
`define ART_RTC_DIV 8
// reset values
`define ART_CNT_RST 8'h00
`define ART_RLD_RST 8'h00
// alternate clock select codes
`define ART_ALT_SYS12 2'h0
`define ART_ALT_RTC8 2'h1
`define ART_ALT_CMP 2'h3
// alternate select bit that picks the capture trigger
`define ART_TRIG_BIT 1
// wrap values
`define ART_BYTE_MAX 8'hFF
`endif

// ==== hw/art_pkg.sv ====
package art_pkg;
    // operating mode of the timer
    typedef enum logic [1:0] {
        ART_MODE_16,
        ART_MODE_SPLIT,
        ART_MODE_CAPTURE
    } art_mode_t;
endpackage : art_pkg

// ==== hw/art_timer.sv ====
// Overview of operation
// - split select picks 16-bit or two 8-bit
// - 16-bit wrap loads reload, sets high flag
// - interrupt on each overflow when enabled
// - low byte wrap interrupts if enabled too
// - split halves reload from own reload byte
// - split: run gates high half only
// - clock select: system clock or alternate
// - rtc and comparator synchronised first
// - split wraps set high and low flags
// - split interrupts: high, or either half
// - flags only cleared by software
// - capture enable enters capture mode
// - trigger bit picks comparator or rtc/8
// - capture copies counter, sets high flag
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module art_timer import art_pkg::*; #(
    parameter int SYS_DIV = `ART_SYS_DIV,
    parameter int RTC_DIV = `ART_RTC_DIV
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_split_mode_sel,
    input wire logic i_run_control,
    input wire logic i_capture_enable,
    input wire logic i_low_byte_irq_enable,
    input wire logic i_timer_irq_enable,
    input wire logic [1:0] i_alternate_clock_select,
    input wire logic i_high_half_clock_select,
    input wire logic i_low_half_clock_select,
    input wire logic i_rtc_clk,
    input wire logic i_comparator_out,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr_count_low,
    input wire logic i_wr_count_high,
    input wire logic i_wr_reload_low,
    input wire logic i_wr_reload_high,
    input wire logic i_clr_high_flag,
    input wire logic i_clr_low_flag,
    output logic [7:0] o_count_low_byte,
    output logic [7:0] o_count_high_byte,
    output logic [7:0] o_reload_low_byte,
    output logic [7:0] o_reload_high_byte,
    output logic o_high_overflow_flag,
    output logic o_low_overflow_flag,
    output logic o_irq
);
    // =========================================================
    // clock source selection
    function automatic logic src_tick(input logic msel,
                                      input logic [1:0] alt,
                                      input logic t12,
                                      input logic trtc,
                                      input logic tcmp);
        logic t;
        t = 1'b0;
        if (msel) begin
            t = 1'b1;
        end else begin
            case (alt)
                `ART_ALT_SYS12: t = t12;
                `ART_ALT_RTC8: t = trtc;
                `ART_ALT_CMP: t = tcmp;
                default: t = 1'b0; // reserved code
            endcase
        end
        return t;
    endfunction : src_tick

    // =========================================================
    // synchronisers and prescalers
    logic rtc_s1, rtc_s2, rtc_s3;
    logic cmp_s1, cmp_s2, cmp_s3;
    logic [3:0] sys_cnt, next_sys_cnt;
    logic [3:0] rtc_cnt, next_rtc_cnt;
    logic tick_sys12, tick_rtc8, tick_cmp, rtc_edge;

    // prescaler next values and tick decode
    always_comb begin
        rtc_edge = rtc_s2 & ~rtc_s3;
        tick_cmp = cmp_s2 & ~cmp_s3;
        tick_sys12 = (sys_cnt == 4'(SYS_DIV - 1));
        tick_rtc8 = rtc_edge && (rtc_cnt == 4'(RTC_DIV - 1));
        next_sys_cnt = tick_sys12 ? 4'h0 : sys_cnt + 4'h1;
        next_rtc_cnt = rtc_cnt;
        if (rtc_edge) begin
            next_rtc_cnt = tick_rtc8 ? 4'h0 : rtc_cnt + 4'h1;
        end
    end

    // two-flop synchronisers plus an edge stage
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rtc_s1 <= 1'b0;
            rtc_s2 <= 1'b0;
            rtc_s3 <= 1'b0;
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
            sys_cnt <= 4'h0;
            rtc_cnt <= 4'h0;
        end else begin
            rtc_s1 <= i_rtc_clk;
            rtc_s2 <= rtc_s1;
            rtc_s3 <= rtc_s2;
            cmp_s1 <= i_comparator_out;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
            sys_cnt <= next_sys_cnt;
            rtc_cnt <= next_rtc_cnt;
        end
    end

    // =========================================================
    // counter, reload and flags
    art_mode_t mode;
    logic tick_lo, tick_hi, en_lo, en_hi, cap_evt;
    logic set_hf, set_lf;
    logic [15:0] cnt16;
    logic [7:0] next_cnt_lo, next_cnt_hi, next_rld_lo, next_rld_hi;
    logic next_hf, next_lf, next_irq;

    assign cnt16 = {o_count_high_byte, o_count_low_byte};

    // mode and enable decode
    always_comb begin
        if (i_capture_enable) begin
            mode = ART_MODE_CAPTURE;
        end else if (i_split_mode_sel) begin
            mode = ART_MODE_SPLIT;
        end else begin
            mode = ART_MODE_16;
        end
        tick_lo = src_tick(i_low_half_clock_select,
            i_alternate_clock_select, tick_sys12, tick_rtc8,
            tick_cmp);
        tick_hi = src_tick(i_high_half_clock_select,
            i_alternate_clock_select, tick_sys12, tick_rtc8,
            tick_cmp);
        cap_evt = i_alternate_clock_select[`ART_TRIG_BIT] ?
            tick_cmp : tick_rtc8;
        en_lo = 1'b0;
        en_hi = 1'b0;
        case (mode)
            ART_MODE_SPLIT: begin
                en_lo = tick_lo;
                en_hi = i_run_control & tick_hi;
            end
            ART_MODE_16, ART_MODE_CAPTURE: begin
                en_lo = i_run_control & tick_lo;
                en_hi = en_lo;
            end
            default: en_hi = 1'b0;
        endcase
    end

    // next counter, reload and flag values
    always_comb begin
        next_cnt_lo = o_count_low_byte;
        next_cnt_hi = o_count_high_byte;
        next_rld_lo = o_reload_low_byte;
        next_rld_hi = o_reload_high_byte;
        set_hf = 1'b0;
        set_lf = 1'b0;
        case (mode)
            ART_MODE_SPLIT: begin
                if (en_lo) begin
                    if (o_count_low_byte == `ART_BYTE_MAX) begin
                        next_cnt_lo = o_reload_low_byte;
                        set_lf = 1'b1;
                    end else begin
                        next_cnt_lo = o_count_low_byte + 8'h01;
                    end
                end
                if (en_hi) begin
                    if (o_count_high_byte == `ART_BYTE_MAX) begin
                        next_cnt_hi = o_reload_high_byte;
                        set_hf = 1'b1;
                    end else begin
                        next_cnt_hi = o_count_high_byte + 8'h01;
                    end
                end
            end
            ART_MODE_16, ART_MODE_CAPTURE: begin
                if (en_lo) begin
                    set_lf = (o_count_low_byte == `ART_BYTE_MAX);
                    if (cnt16 == {`ART_BYTE_MAX, `ART_BYTE_MAX} &&
                        mode == ART_MODE_16) begin
                        next_cnt_lo = o_reload_low_byte;
                        next_cnt_hi = o_reload_high_byte;
                        set_hf = 1'b1;
                    end else begin
                        {next_cnt_hi, next_cnt_lo} = cnt16 + 16'h0001;
                    end
                end
                if (mode == ART_MODE_CAPTURE && cap_evt) begin
                    next_rld_lo = o_count_low_byte;
                    next_rld_hi = o_count_high_byte;
                    set_hf = 1'b1;
                end
            end
            default: set_hf = 1'b0;
        endcase
        if (i_wr_count_low) begin
            next_cnt_lo = i_wr_data;
        end
        if (i_wr_count_high) begin
            next_cnt_hi = i_wr_data;
        end
        if (i_wr_reload_low && !(mode == ART_MODE_CAPTURE && cap_evt)) begin
            next_rld_lo = i_wr_data;
        end
        if (i_wr_reload_high && !(mode == ART_MODE_CAPTURE && cap_evt)) begin
            next_rld_hi = i_wr_data;
        end
        // set wins over a same-cycle clear
        next_hf = (o_high_overflow_flag & ~i_clr_high_flag) | set_hf;
        next_lf = (o_low_overflow_flag & ~i_clr_low_flag) | set_lf;
        // request follows the sticky flags
        next_irq = i_timer_irq_enable & (o_high_overflow_flag |
            (i_low_byte_irq_enable & o_low_overflow_flag));
    end

    // register the timer state
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_count_low_byte <= `ART_CNT_RST;
            o_count_high_byte <= `ART_CNT_RST;
            o_reload_low_byte <= `ART_RLD_RST;
            o_reload_high_byte <= `ART_RLD_RST;
            o_high_overflow_flag <= 1'b0;
            o_low_overflow_flag <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_count_low_byte <= next_cnt_lo;
            o_count_high_byte <= next_cnt_hi;
            o_reload_low_byte <= next_rld_lo;
            o_reload_high_byte <= next_rld_hi;
            o_high_overflow_flag <= next_hf;
            o_low_overflow_flag <= next_lf;
            o_irq <= next_irq;
        end
    end

    // =========================================================
    // assertions
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    logic no_wr;
    assign no_wr = !i_wr_count_low && !i_wr_count_high;

    sequence s_wrap16;
        mode == ART_MODE_16 && en_lo && no_wr &&
            cnt16 == 16'hFFFF;
    endsequence
    property p_wrap16;
        s_wrap16 |=> cnt16 == {$past(o_reload_high_byte),
            $past(o_reload_low_byte)} && o_high_overflow_flag;
    endproperty
    a_wrap16: assert property (p_wrap16)
        else $error("16-bit wrap did not reload");
    property p_irq_high;
        i_timer_irq_enable && o_high_overflow_flag |=> o_irq;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("missing overflow interrupt");
    property p_irq_low;
        i_timer_irq_enable && i_low_byte_irq_enable &&
            o_low_overflow_flag |=> o_irq;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("missing low byte interrupt");
    property p_irq_off;
        !i_timer_irq_enable |=> !o_irq;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt while disabled");
    property p_split_lo;
        mode == ART_MODE_SPLIT && en_lo && !i_wr_count_low &&
            o_count_low_byte == 8'hFF |=>
            o_count_low_byte == $past(o_reload_low_byte) &&
            o_low_overflow_flag;
    endproperty
    a_split_lo: assert property (p_split_lo)
        else $error("low half did not reload");
    property p_hi_hold;
        mode == ART_MODE_SPLIT && !i_run_control &&
            !i_wr_count_high |=> $stable(o_count_high_byte);
    endproperty
    a_hi_hold: assert property (p_hi_hold)
        else $error("high half counted while stopped");
    property p_sticky;
        o_high_overflow_flag && !i_clr_high_flag |=>
            o_high_overflow_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("high flag cleared by itself");
    sequence s_cap;
        mode == ART_MODE_CAPTURE && cap_evt;
    endsequence
    property p_capture;
        s_cap |=> {o_reload_high_byte, o_reload_low_byte} ==
            $past(cnt16) && o_high_overflow_flag;
    endproperty
    a_capture: assert property (p_capture)
        else $error("capture did not copy counter");
    property p_sys12;
        tick_sys12 |=> !tick_sys12 [*8] ##1 !tick_sys12 [*3]
            ##1 tick_sys12;
    endproperty
    a_sys12: assert property (p_sys12)
        else $error("divide by 12 tick off period");
    sequence s_cmp_rise;
        $rose(i_comparator_out) ##1 i_comparator_out;
    endsequence
    property p_cmp_sync;
        s_cmp_rise |=> tick_cmp;
    endproperty
    a_cmp_sync: assert property (p_cmp_sync)
        else $error("comparator edge not seen after sync");
    property p_count_step;
        mode == ART_MODE_16 && i_run_control &&
            i_low_half_clock_select && no_wr && cnt16 != 16'hFFFF
            |=> cnt16 == $past(cnt16) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step on system clock");
endmodule : art_timer
`default_nettype wire

// ==== verification/auto_reload_timer_with_capture_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "art_map.svh"

module auto_reload_timer_with_capture_tb_top;
    // ==========================================
    // stimulus and design
    // ==========================================
    logic i_core_clk, i_reset, split, cap, run, len, ie, hsel, lsel;
    logic rtc, cmp, clrh, clrl, armed;
    logic [1:0] alt;
    logic [3:0] wr_s;
    logic [7:0] d, lo_q, hi_q, rl_q, rh_q;
    logic hf_q, lf_q, irq_q;
    int err_count, checks_done;

    art_timer art_timer_i (
        .i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_split_mode_sel(split), .i_run_control(run),
        .i_capture_enable(cap), .i_low_byte_irq_enable(len),
        .i_timer_irq_enable(ie), .i_alternate_clock_select(alt),
        .i_high_half_clock_select(hsel), .i_low_half_clock_select(lsel),
        .i_rtc_clk(rtc), .i_comparator_out(cmp), .i_wr_data(d),
        .i_wr_count_low(wr_s[0]), .i_wr_count_high(wr_s[1]),
        .i_wr_reload_low(wr_s[2]), .i_wr_reload_high(wr_s[3]),
        .i_clr_high_flag(clrh), .i_clr_low_flag(clrl),
        .o_count_low_byte(lo_q), .o_count_high_byte(hi_q),
        .o_reload_low_byte(rl_q), .o_reload_high_byte(rh_q),
        .o_high_overflow_flag(hf_q), .o_low_overflow_flag(lf_q),
        .o_irq(irq_q)
    );

    // clock at 200 MHz
    initial begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end

    // ==========================================
    // behavioural model
    // ==========================================
    logic [15:0] mc, nc;
    logic [7:0] mrl, mrh;
    logic hf, lf, mirq, t12, rr, cr, trtc, at, lt, ht, ev;
    logic [2:0] sr, sc;
    int p12, pr;

    // next state of the timer, same edge as the design
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            mc = 16'h0000;
            mrl = 8'h00;
            mrh = 8'h00;
            hf = 1'b0;
            lf = 1'b0;
            mirq = 1'b0;
            p12 = 0;
            pr = 0;
            sr = 3'h0;
            sc = 3'h0;
        end else begin
            t12 = (p12 == `ART_SYS_DIV - 1);
            p12 = t12 ? 0 : p12 + 1;
            rr = sr[1] & ~sr[2];
            cr = sc[1] & ~sc[2];
            trtc = rr && (pr == `ART_RTC_DIV - 1);
            if (rr) pr = trtc ? 0 : pr + 1;
            sr = {sr[1:0], rtc};
            sc = {sc[1:0], cmp};
            case (alt)
                `ART_ALT_SYS12: at = t12;
                `ART_ALT_RTC8: at = trtc;
                `ART_ALT_CMP: at = cr;
                default: at = 1'b0;
            endcase
            lt = lsel | at;
            ht = hsel | at;
            ev = cap & (alt[`ART_TRIG_BIT] ? cr : trtc);
            mirq = ie & (hf | (len & lf));
            if (clrh) hf = 1'b0;
            if (clrl) lf = 1'b0;
            nc = mc;
            if (cap || !split) begin
                if (run & lt) begin
                    if (mc[7:0] == `ART_BYTE_MAX) lf = 1'b1;
                    if (mc == 16'hFFFF && !cap) begin
                        nc = {mrh, mrl};
                        hf = 1'b1;
                    end else nc = mc + 16'h0001;
                end
            end else begin
                if (lt) begin
                    if (mc[7:0] == `ART_BYTE_MAX) begin
                        nc[7:0] = mrl;
                        lf = 1'b1;
                    end else nc[7:0] = mc[7:0] + 8'h01;
                end
                if (run & ht) begin
                    if (mc[15:8] == `ART_BYTE_MAX) begin
                        nc[15:8] = mrh;
                        hf = 1'b1;
                    end else nc[15:8] = mc[15:8] + 8'h01;
                end
            end
            if (ev) begin
                {mrh, mrl} = mc;
                hf = 1'b1;
            end else begin
                if (wr_s[2]) mrl = d;
                if (wr_s[3]) mrh = d;
            end
            if (wr_s[0]) nc[7:0] = d;
            if (wr_s[1]) nc[15:8] = d;
            mc = nc;
        end
    end

    // ==========================================
    // comparison
    // ==========================================
    task chk_byte(input logic [7:0] got, input logic [7:0] exp,
                  input string m);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_byte

    task chk_bit(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
        end
    endtask : chk_bit

    // every result compared once the first edge has landed
    always @(negedge i_core_clk) begin
        if (armed) begin
            chk_byte(lo_q, mc[7:0], "count low");
            chk_byte(hi_q, mc[15:8], "count high");
            chk_byte(rl_q, mrl, "reload low");
            chk_byte(rh_q, mrh, "reload high");
            chk_bit(hf_q, hf, "high flag");
            chk_bit(lf_q, lf, "low flag");
            chk_bit(irq_q, mirq, "irq");
        end
    end

    // ==========================================
    // stimulus tasks
    // ==========================================
    // random slow clock, comparator and software flag clears
    always @(posedge i_core_clk) begin
        if (!i_reset) begin
            rtc <= ($urandom % 4 == 0) ? ~rtc : rtc;
            cmp <= ($urandom % 5 == 0) ? ~cmp : cmp;
            clrh <= ($urandom % 48 == 0);
            clrl <= ($urandom % 48 == 0);
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : cyc

    task wr(input int sel, input logic [7:0] v);
        @(posedge i_core_clk);
        wr_s <= 4'h1 << sel;
        d <= v;
        @(posedge i_core_clk);
        wr_s <= 4'h0;
    endtask : wr

    task cfg(input logic s, c, r, l, h, input logic [1:0] a,
             input logic e, n);
        @(posedge i_core_clk);
        split <= s;
        cap <= c;
        run <= r;
        lsel <= l;
        hsel <= h;
        alt <= a;
        ie <= e;
        len <= n;
    endtask : cfg

    task stop_test;
        if (err_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        {split, cap, run, len, ie, hsel, lsel, rtc, cmp} = 9'h000;
        {clrh, clrl, armed, alt, wr_s, d} = 17'h00000;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'hC3ED));
        i_reset = 1'b1;
        cyc(1);
        armed <= 1'b1;
        cyc(3);
        i_reset <= 1'b0;
        // 16-bit wrap with reload and both interrupt sources
        cfg(0, 0, 0, 1, 0, 2'h0, 1, 1);
        wr(0, 8'hF8);
        wr(1, 8'hFF);
        wr(2, 8'($urandom));
        wr(3, 8'($urandom));
        cfg(0, 0, 1, 1, 0, 2'h0, 1, 1);
        cyc(40);
        // every alternate source, reserved code included
        for (int a = 0; a < 4; a++) begin
            wr(0, 8'hF0);
            wr(1, 8'hFF);
            cfg(0, 0, 1, 0, 0, a[1:0], 1, a[0]);
            cyc(400);
        end
        // reset in mid-run; the prescalers restart
        i_reset <= 1'b1;
        cyc(2);
        i_reset <= 1'b0;
        // split mode, high half stopped then running, irq off first
        cfg(1, 0, 0, 1, 0, 2'h0, 0, 1);
        wr(0, 8'hFC);
        wr(1, 8'hFE);
        wr(2, 8'($urandom));
        wr(3, 8'($urandom));
        cyc(30);
        cfg(1, 0, 1, 1, 0, 2'h0, 1, 1);
        cyc(300);
        cfg(1, 0, 1, 0, 1, 2'h3, 1, 0);
        cyc(300);
        // capture on comparator then on slow clock; counter set near wrap
        cfg(0, 1, 1, 1, 0, 2'h3, 1, 0);
        wr(0, 8'hF0);
        wr(1, 8'hFF);
        cyc(300);
        wr(2, 8'($urandom));
        cfg(0, 1, 1, 1, 0, 2'h1, 1, 1);
        cyc(800);
        stop_test();
    end
endmodule : auto_reload_timer_with_capture_tb_top

`default_nettype wire
